// ===== rtl/baud_tick_gen.sv
// Baud divisor timer producing one pulse per bit period
`timescale 1ns/1ps
module baud_tick_gen (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic clear_in,
	input wire logic [uart_tx_pkg::DIV_W-1:0] divisor_in,
	output logic bit_tick_out
);
	import uart_tx_pkg::*;

	typedef struct packed {
		logic [DIV_W-1:0] div_cnt;
		logic [SUB_W-1:0] sub_cnt;
		logic bit_tick;
	} baud_t;

	baud_t r;
	baud_t nxt;

	assign bit_tick_out = r.bit_tick;

	always_comb begin
		nxt = r;
		nxt.bit_tick = 1'b0;
		if (clear_in) begin
			nxt.div_cnt = '0; // R25
			nxt.sub_cnt = '0;
		end else if (r.div_cnt == divisor_in) begin
			// Period is sixteen times divisor plus one
			nxt.div_cnt = '0; // R24
			nxt.sub_cnt = r.sub_cnt + 4'h1;
			nxt.bit_tick = (r.sub_cnt == SUB_LAST);
		end else begin
			nxt.div_cnt = r.div_cnt + 16'h0001;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			r <= '0;
		end else begin
			r <= nxt;
		end
	end
endmodule

// ===== rtl/tx_fifo_if.sv
// Carrier between the transmitter and its word store
`timescale 1ns/1ps
interface tx_fifo_if;
	import uart_tx_pkg::*;
	logic push_valid;
	logic push_ready;
	logic [DATA_W-1:0] push_data;
	logic pop_valid;
	logic pop_ready;
	logic [DATA_W-1:0] pop_data;
	logic flush;
	logic [COUNT_W-1:0] count;

	modport writer(output push_valid, output push_data, output pop_ready, output flush,
		input push_ready, input pop_valid, input pop_data, input count);
	modport store(input push_valid, input push_data, input pop_ready, input flush,
		output push_ready, output pop_valid, output pop_data, output count);
endinterface

// ===== rtl/tx_word_store.sv
// Four-word transmit FIFO with valid and ready on both sides
`timescale 1ns/1ps
module tx_word_store (
	input wire logic clk_in,
	input wire logic rst_n_in,
	tx_fifo_if.store fifo
);
	import uart_tx_pkg::*;

	typedef struct packed {
		logic [FIFO_DEPTH-1:0][DATA_W-1:0] mem;
		logic [PTR_W-1:0] wr_ptr;
		logic [PTR_W-1:0] rd_ptr;
		logic [COUNT_W-1:0] count;
		logic [DATA_W-1:0] head;
	} store_t;

	store_t r;
	store_t nxt;
	logic do_push;
	logic do_pop;

	assign fifo.push_ready = (r.count != FIFO_FULL_COUNT) && !fifo.flush;
	assign fifo.pop_valid = (r.count != 3'h0) && !fifo.flush;
	assign fifo.pop_data = r.head;
	assign fifo.count = r.count;
	assign do_push = fifo.push_valid && fifo.push_ready;
	assign do_pop = fifo.pop_valid && fifo.pop_ready;

	always_comb begin
		nxt = r;
		if (fifo.flush) begin
			nxt.wr_ptr = '0;
			nxt.rd_ptr = '0;
			nxt.count = '0;
		end else begin
			if (do_push) begin
				nxt.mem[r.wr_ptr] = fifo.push_data;
				nxt.wr_ptr = r.wr_ptr + 2'h1;
			end
			if (do_pop) begin
				nxt.rd_ptr = r.rd_ptr + 2'h1;
			end
			if (do_push && !do_pop) begin
				nxt.count = r.count + 3'h1;
			end else if (do_pop && !do_push) begin
				nxt.count = r.count - 3'h1;
			end
		end
		// Registered head word for the read side
		nxt.head = nxt.mem[nxt.rd_ptr];
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			r <= '0;
		end else begin
			r <= nxt;
		end
	end
endmodule

// ===== rtl/uart_tx_pkg.sv
// Shared constants and types for the serial port configuration and transmitter
package uart_tx_pkg;

	localparam int DIV_W = 16;
	localparam int DATA_W = 9;
	localparam int FIFO_DEPTH = 4;
	localparam int PTR_W = 2;
	localparam int COUNT_W = 3;
	localparam int SUB_W = 4;
	localparam int BITCNT_W = 4;

	// Sixteen divider ticks make one bit period
	localparam logic [SUB_W-1:0] SUB_LAST = 4'hf;

	// Frame format codes of data_parity_select
	localparam logic [1:0] DPS_8N = 2'h0;
	localparam logic [1:0] DPS_8E = 2'h1;
	localparam logic [1:0] DPS_8O = 2'h2;
	localparam logic [1:0] DPS_9N = 2'h3;

	// Index of the last data bit for eight and nine bit frames
	localparam logic [BITCNT_W-1:0] LAST_BIT_8 = 4'h7;
	localparam logic [BITCNT_W-1:0] LAST_BIT_9 = 4'h8;

	// Values after reset, and the FIFO full and one-word counts
	localparam logic [1:0] RST_DATA_PARITY = DPS_8N;
	localparam logic RST_STOP_TWO = 1'b0;
	localparam logic RST_MODULE_ENABLE = 1'b0;
	localparam logic RST_ALT_PINS = 1'b0;
	localparam logic [DIV_W-1:0] RST_DIVISOR = 16'h0000;
	localparam logic RST_TX_INT_SEL = 1'b0;
	localparam logic [COUNT_W-1:0] FIFO_FULL_COUNT = 3'h4;
	localparam logic [COUNT_W-1:0] FIFO_ONE_COUNT = 3'h1;

	typedef enum logic [2:0] {
		TX_IDLE,
		TX_WAIT,
		TX_START,
		TX_DATA,
		TX_PARITY,
		TX_STOP
	} tx_state_t;

endpackage

// ===== rtl/uart_tx_top.sv
// Serial port configuration, enable logic and transmitter
//
// Summary of operation
// R01 - Frames are start bit, eight or nine data bits, optional parity, one or two stops.
// R02 - After reset the format is eight data bits, no parity, one stop.
// R03 - Format comes from data_parity_select and stop_bit_select mode fields.
// R04 - Bits leave least significant first; format and rate shared with receiver.
// R05 - With module and transmit enabled the port owns the serial pins.
// R06 - The line idles high while enabled and not sending.
// R07 - Software enables the module before transmit_enable; otherwise the set is ignored.
// R08 - Reset leaves the module disabled; disabled pins return to port control.
// R09 - Disabling empties the buffers and clears the baud timer.
// R10 - Disabling clears enable, break and full flags; sets the idle flags.
// R11 - Disabling aborts activity; re-enabling resumes with kept configuration.
// R12 - alternate_pin_select chooses alternate pins instead of primary ones.
// R13 - The shift register reloads from the FIFO right after the stop bit.
// R14 - Sending starts with data, transmit_enable and a tick, in any order.
// R15 - Clearing transmit_enable aborts, resets the transmitter and releases the output.
// R16 - Nine-bit mode sends bit 8 as ninth data bit with no parity.
// R17 - The FIFO holds four 9-bit words; full flag set; writes when full dropped.
// R18 - Any device reset empties the FIFO; power modes leave it alone.
// R19 - tx_interrupt_select chooses interrupt per transfer or on emptying transfer.
// R20 - Interrupt on first enable, and on transmit_enable set with select zero.
// R21 - shift_register_empty shows an empty shift register and raises no interrupt.
// R22 - send_break forces the line low over everything and raises no interrupt.
// R23 - Software times the break for thirteen bits and waits before new data.
// R24 - Bit period is sixteen times divisor plus one clocks.
// R25 - A divisor write clears the baud timer immediately.
// R26 - Byte writes enqueue only eight bits; the ninth is ignored in eight-bit modes.
`timescale 1ns/1ps
module uart_tx_top (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic mode_wr_in,
	input wire logic module_enable_in,
	input wire logic alternate_pin_select_in,
	input wire logic [1:0] data_parity_select_in,
	input wire logic stop_bit_select_in,
	input wire logic status_wr_in,
	input wire logic tx_interrupt_select_in,
	input wire logic transmit_enable_in,
	input wire logic send_break_in,
	input wire logic baud_wr_in,
	input wire logic [uart_tx_pkg::DIV_W-1:0] baud_divisor_in,
	input wire logic tx_data_valid_in,
	input wire logic tx_data_word_in,
	input wire logic [uart_tx_pkg::DATA_W-1:0] tx_data_in,
	output logic tx_data_ready_out,
	input wire logic serial_in_in,
	input wire logic alternate_serial_in_in,
	output logic serial_out_out,
	output logic serial_out_oe_n_out,
	output logic alternate_serial_out_out,
	output logic alternate_serial_out_oe_n_out,
	output logic rx_line_out,
	output logic pins_owned_out,
	output logic rx_reset_out,
	output logic module_enable_out,
	output logic alternate_pin_select_out,
	output logic [1:0] data_parity_select_out,
	output logic stop_bit_select_out,
	output logic [uart_tx_pkg::DIV_W-1:0] baud_divisor_out,
	output logic tx_interrupt_select_out,
	output logic transmit_enable_out,
	output logic send_break_out,
	output logic transmit_buffer_full_out,
	output logic shift_register_empty_out,
	output logic tx_interrupt_out
);
	import uart_tx_pkg::*;

	typedef struct packed {
		logic module_enable;
		logic alt_pins;
		logic [1:0] dps;
		logic stop_two;
		logic [DIV_W-1:0] divisor;
		logic tx_int_sel;
		logic tx_enable;
		logic send_break;
		logic was_enabled;
		tx_state_t state;
		logic [DATA_W-1:0] shreg;
		logic parity;
		logic [BITCNT_W-1:0] bit_cnt;
		logic tsr_empty;
		logic out_bit;
		logic int_pulse;
		logic buf_full;
	} top_t;

	top_t r;
	top_t nxt;
	logic [1:0] rst_sync_ff;
	logic rst_n;
	logic bit_tick;
	logic baud_clear;
	logic push_fire;
	logic pop_fire;
	logic line_level;
	logic line_drive;
	logic transfer_int;

	tx_fifo_if fifo();

	// Reset release through two flops
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rst_sync_ff <= 2'h0;
		end else begin
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_ff[1];

	assign baud_clear = baud_wr_in || !r.module_enable; // R09 R25

	baud_tick_gen u_baud (
		.clk_in(clk_in),
		.rst_n_in(rst_n),
		.clear_in(baud_clear),
		.divisor_in(r.divisor),
		.bit_tick_out(bit_tick)
	);

	tx_word_store u_store (
		.clk_in(clk_in),
		.rst_n_in(rst_n), // R18
		.fifo(fifo)
	);

	// Write side of the FIFO
	assign fifo.flush = !r.module_enable; // R09
	assign fifo.push_valid = tx_data_valid_in;
	// Byte writes carry only the low eight bits
	assign fifo.push_data = tx_data_word_in ? tx_data_in : {1'b0, tx_data_in[7:0]}; // R26
	assign tx_data_ready_out = fifo.push_ready; // R17
	assign push_fire = fifo.push_valid && fifo.push_ready;
	assign pop_fire = fifo.pop_valid && fifo.pop_ready;

	// Interrupt for a FIFO to shift register transfer
	assign transfer_int = !r.tx_int_sel
		|| ((fifo.count == FIFO_ONE_COUNT) && !push_fire); // R19

	// Loads the shift register from the FIFO head
	function automatic top_t load_word(input top_t s, input logic [DATA_W-1:0] w);
		top_t t;
		t = s;
		if (s.dps == DPS_9N) begin
			t.shreg = w; // R16
		end else begin
			t.shreg = {1'b0, w[7:0]}; // R26
		end
		t.parity = (s.dps == DPS_8O) ? ~^w[7:0] : ^w[7:0];
		t.bit_cnt = '0;
		t.tsr_empty = 1'b0;
		return t;
	endfunction

	always_comb begin
		nxt = r;
		nxt.int_pulse = 1'b0;
		fifo.pop_ready = 1'b0;

		// Mode register write
		if (mode_wr_in) begin
			nxt.module_enable = module_enable_in;
			nxt.alt_pins = alternate_pin_select_in; // R12
			nxt.dps = data_parity_select_in; // R03
			nxt.stop_two = stop_bit_select_in; // R03
		end
		if (baud_wr_in) begin
			nxt.divisor = baud_divisor_in;
		end

		// Status register write; enables only take while the module runs
		if (status_wr_in) begin
			nxt.tx_int_sel = tx_interrupt_select_in;
			if (r.module_enable) begin
				nxt.tx_enable = transmit_enable_in; // R07
				nxt.send_break = send_break_in;
			end
		end

		// Interrupt on first enable and on transmit enable with select zero
		nxt.was_enabled = r.module_enable;
		if (r.module_enable && !r.was_enabled) begin
			nxt.int_pulse = 1'b1; // R20
		end
		if (status_wr_in && r.module_enable && transmit_enable_in && !r.tx_enable
			&& !nxt.tx_int_sel) begin
			nxt.int_pulse = 1'b1; // R20
		end

		// Transmitter
		if (!r.module_enable || !r.tx_enable) begin
			// Abort resets the shift path
			nxt.state = TX_IDLE; // R11 R15
			nxt.out_bit = 1'b1;
			nxt.tsr_empty = 1'b1;
			nxt.bit_cnt = '0;
		end else begin
			unique case (r.state)
				TX_IDLE: begin
					nxt.out_bit = 1'b1; // R06
					if (fifo.pop_valid) begin
						// Empty shift register takes the word at once
						fifo.pop_ready = 1'b1; // R14
						nxt = load_word(nxt, fifo.pop_data);
						nxt.state = TX_WAIT;
						nxt.int_pulse = nxt.int_pulse | transfer_int; // R19
					end
				end
				TX_WAIT: begin
					if (bit_tick) begin
						nxt.state = TX_START; // R14
						nxt.out_bit = 1'b0; // R01
					end
				end
				TX_START: begin
					if (bit_tick) begin
						nxt.state = TX_DATA;
						nxt.out_bit = r.shreg[0]; // R04
						nxt.shreg = r.shreg >> 1;
					end
				end
				TX_DATA: begin
					if (bit_tick) begin
						if (r.bit_cnt == ((r.dps == DPS_9N) ? LAST_BIT_9 : LAST_BIT_8)) begin // R01
							nxt.bit_cnt = '0;
							if ((r.dps == DPS_8E) || (r.dps == DPS_8O)) begin
								nxt.state = TX_PARITY;
								nxt.out_bit = r.parity; // R01
							end else begin
								nxt.state = TX_STOP;
								nxt.out_bit = 1'b1;
							end
						end else begin
							nxt.bit_cnt = r.bit_cnt + 4'h1;
							nxt.out_bit = r.shreg[0]; // R04
							nxt.shreg = r.shreg >> 1;
						end
					end
				end
				TX_PARITY: begin
					if (bit_tick) begin
						nxt.state = TX_STOP;
						nxt.out_bit = 1'b1;
						nxt.bit_cnt = '0;
					end
				end
				TX_STOP: begin
					if (bit_tick) begin
						if (r.stop_two && (r.bit_cnt == 4'h0)) begin
							nxt.bit_cnt = 4'h1; // R01
						end else if (fifo.pop_valid) begin
							// Reload straight after the last stop bit
							fifo.pop_ready = 1'b1; // R13
							nxt = load_word(nxt, fifo.pop_data);
							nxt.state = TX_START;
							nxt.out_bit = 1'b0;
							nxt.int_pulse = nxt.int_pulse | transfer_int; // R19
						end else begin
							nxt.state = TX_IDLE;
							nxt.tsr_empty = 1'b1; // R21
						end
					end
				end
			endcase
		end

		// Disable clears the transmit enable and break bits
		if (!nxt.module_enable) begin
			nxt.tx_enable = 1'b0; // R10
			nxt.send_break = 1'b0; // R10
		end
		nxt.buf_full = r.module_enable && (fifo.count == FIFO_FULL_COUNT); // R17 R10
	end

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			r.module_enable <= RST_MODULE_ENABLE; // R08
			r.alt_pins <= RST_ALT_PINS;
			r.dps <= RST_DATA_PARITY; // R02
			r.stop_two <= RST_STOP_TWO; // R02
			r.divisor <= RST_DIVISOR;
			r.tx_int_sel <= RST_TX_INT_SEL;
			r.tx_enable <= 1'b0;
			r.send_break <= 1'b0;
			r.was_enabled <= 1'b0;
			r.state <= TX_IDLE;
			r.shreg <= '0;
			r.parity <= 1'b0;
			r.bit_cnt <= '0;
			r.tsr_empty <= 1'b1;
			r.out_bit <= 1'b1;
			r.int_pulse <= 1'b0;
			r.buf_full <= 1'b0;
		end else begin
			r <= nxt;
		end
	end

	// Pin ownership and line level
	assign line_drive = r.module_enable && (r.tx_enable || r.send_break); // R05 R15
	assign line_level = r.send_break ? 1'b0 : r.out_bit; // R22
	assign serial_out_out = line_level;
	assign alternate_serial_out_out = line_level;
	assign serial_out_oe_n_out = !(line_drive && !r.alt_pins); // R12
	assign alternate_serial_out_oe_n_out = !(line_drive && r.alt_pins); // R12
	assign rx_line_out = r.alt_pins ? alternate_serial_in_in : serial_in_in; // R05 R12
	assign pins_owned_out = r.module_enable; // R05 R08
	assign rx_reset_out = !r.module_enable; // R10

	// Status readback
	assign module_enable_out = r.module_enable;
	assign alternate_pin_select_out = r.alt_pins;
	assign data_parity_select_out = r.dps;
	assign stop_bit_select_out = r.stop_two;
	assign baud_divisor_out = r.divisor;
	assign tx_interrupt_select_out = r.tx_int_sel;
	assign transmit_enable_out = r.tx_enable;
	assign send_break_out = r.send_break;
	assign transmit_buffer_full_out = r.buf_full;
	assign shift_register_empty_out = r.tsr_empty; // R21
	// Break has no path onto the interrupt pulse
	assign tx_interrupt_out = r.int_pulse; // R22
endmodule

// ===== testbench/uart_line_rx.sv
// Remote receiver that decodes frames from the line
`timescale 1ns/1ps
module uart_line_rx (
	input wire logic clk_in,
	input wire logic line_in,
	input wire logic [3:0] nbits_in,
	output logic [8:0] word_out,
	output int frames_out
);
	initial begin
		word_out = 9'h000;
		frames_out = 0;
		forever begin
			@(negedge clk_in);
			if (line_in === 1'b0) begin
				repeat (8) @(negedge clk_in);
				for (int i = 0; i < nbits_in; i++) begin
					repeat (16) @(negedge clk_in);
					word_out[i] = line_in;
				end
				repeat (16) @(negedge clk_in);
				frames_out += (line_in === 1'b1) ? 1 : 0;
			end
		end
	end
endmodule

// ===== testbench/uart_tx_checker.sv
// Port assertions for the serial transmitter
`timescale 1ns/1ps
module uart_tx_checker (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic status_wr_in,
	input wire logic transmit_enable_in,
	input wire logic tx_data_ready_out,
	input wire logic serial_out_out,
	input wire logic serial_out_oe_n_out,
	input wire logic alternate_serial_out_out,
	input wire logic alternate_serial_out_oe_n_out,
	input wire logic rx_reset_out,
	input wire logic module_enable_out,
	input wire logic alternate_pin_select_out,
	input wire logic transmit_enable_out,
	input wire logic send_break_out,
	input wire logic transmit_buffer_full_out,
	input wire logic shift_register_empty_out,
	input wire logic tx_interrupt_out
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!resetn_in);
	sequence s_load;
		$fell(shift_register_empty_out) && !send_break_out;
	endsequence
	sequence s_start_bit;
		##[1:40] !(alternate_pin_select_out ? alternate_serial_out_out : serial_out_out);
	endsequence
	property p_idle; shift_register_empty_out && !send_break_out |-> serial_out_out; endproperty
	a_idle: assert property (p_idle) else $error("line not high at idle");
	property p_break; send_break_out |-> !serial_out_out && !alternate_serial_out_out; endproperty
	a_break: assert property (p_break) else $error("break not low");
	property p_drive; module_enable_out && transmit_enable_out |->
		serial_out_oe_n_out == alternate_pin_select_out &&
		alternate_serial_out_oe_n_out != alternate_pin_select_out; endproperty
	a_drive: assert property (p_drive) else $error("wrong pin driven");
	property p_off; !module_enable_out |-> serial_out_oe_n_out && alternate_serial_out_oe_n_out &&
		rx_reset_out && !tx_data_ready_out; endproperty
	a_off: assert property (p_off) else $error("disabled port still active");
	property p_refuse; status_wr_in && transmit_enable_in && !module_enable_out |=>
		!transmit_enable_out; endproperty
	a_refuse: assert property (p_refuse) else $error("enable taken while off");
	property p_clear; $fell(module_enable_out) |=> !transmit_enable_out && !send_break_out &&
		!transmit_buffer_full_out && shift_register_empty_out; endproperty
	a_clear: assert property (p_clear) else $error("flags not reset on disable");
	property p_first_int; $rose(module_enable_out) |=> tx_interrupt_out; endproperty
	a_first_int: assert property (p_first_int) else $error("no enable interrupt");
	property p_start; s_load |-> s_start_bit; endproperty
	a_start: assert property (p_start) else $error("start bit late");
	property p_release; $fell(transmit_enable_out) && module_enable_out && !send_break_out |->
		serial_out_oe_n_out && alternate_serial_out_oe_n_out ##[0:2] shift_register_empty_out;
	endproperty
	a_release: assert property (p_release) else $error("line not released");
endmodule

bind uart_tx_top uart_tx_checker u_chk (.clk_in, .resetn_in, .status_wr_in, .transmit_enable_in,
	.tx_data_ready_out, .serial_out_out, .serial_out_oe_n_out, .alternate_serial_out_out,
	.alternate_serial_out_oe_n_out, .rx_reset_out, .module_enable_out, .alternate_pin_select_out,
	.transmit_enable_out, .send_break_out, .transmit_buffer_full_out, .shift_register_empty_out,
	.tx_interrupt_out);

// ===== testbench/uart_tx_top_tb.sv
// Self-checking bench for the serial port transmitter
`timescale 1ns/1ps
`define CHK(n, e, a) \
	begin \
		n_checks++; \
		if ((a) !== (e)) begin \
			n_mismatch++; \
			$display("Error %s expected %h seen %h", n, e, a); \
		end \
	end
module uart_tx_top_tb;
	import uart_tx_pkg::*;
	logic clk_in = 1'b0, resetn_in = 1'b0, mode_wr_in = 1'b0, module_enable_in = 1'b0;
	logic alternate_pin_select_in = 1'b0, stop_bit_select_in = 1'b0, status_wr_in = 1'b0;
	logic tx_interrupt_select_in = 1'b0, transmit_enable_in = 1'b0, send_break_in = 1'b0;
	logic baud_wr_in = 1'b0, tx_data_valid_in = 1'b0, tx_data_word_in = 1'b1;
	logic serial_in_in = 1'b1, alternate_serial_in_in = 1'b0;
	logic [1:0] data_parity_select_in = 2'h0;
	logic [DIV_W-1:0] baud_divisor_in = 16'h0000;
	logic [DATA_W-1:0] tx_data_in = 9'h000;
	logic tx_data_ready_out, serial_out_out, serial_out_oe_n_out, alternate_serial_out_out;
	logic alternate_serial_out_oe_n_out, rx_line_out, pins_owned_out, rx_reset_out;
	logic module_enable_out, alternate_pin_select_out, stop_bit_select_out, send_break_out;
	logic tx_interrupt_select_out, transmit_enable_out, transmit_buffer_full_out;
	logic shift_register_empty_out, tx_interrupt_out;
	logic [1:0] data_parity_select_out;
	logic [DIV_W-1:0] baud_divisor_out;
	logic [8:0] word_p, word_a;
	int frames_p, frames_a, n_int = 0, n_checks = 0, n_mismatch = 0, cycles = 0;
	// Released pins are pulled up
	wire logic line_p = serial_out_oe_n_out ? 1'b1 : serial_out_out;
	wire logic line_a = alternate_serial_out_oe_n_out ? 1'b1 : alternate_serial_out_out;
	wire logic [3:0] nbits = (data_parity_select_out == DPS_8N) ? 4'h8 : 4'h9;
	uart_tx_top u_dut (.clk_in, .resetn_in, .mode_wr_in, .module_enable_in,
		.alternate_pin_select_in, .data_parity_select_in, .stop_bit_select_in, .status_wr_in,
		.tx_interrupt_select_in, .transmit_enable_in, .send_break_in, .baud_wr_in,
		.baud_divisor_in, .tx_data_valid_in, .tx_data_word_in, .tx_data_in, .tx_data_ready_out,
		.serial_in_in, .alternate_serial_in_in, .serial_out_out, .serial_out_oe_n_out,
		.alternate_serial_out_out, .alternate_serial_out_oe_n_out, .rx_line_out, .pins_owned_out,
		.rx_reset_out, .module_enable_out, .alternate_pin_select_out, .data_parity_select_out,
		.stop_bit_select_out, .baud_divisor_out, .tx_interrupt_select_out, .transmit_enable_out,
		.send_break_out, .transmit_buffer_full_out, .shift_register_empty_out, .tx_interrupt_out);
	uart_line_rx u_rx_p (.clk_in, .line_in(line_p), .nbits_in(nbits), .word_out(word_p),
		.frames_out(frames_p));
	uart_line_rx u_rx_a (.clk_in, .line_in(line_a), .nbits_in(nbits), .word_out(word_a),
		.frames_out(frames_a));
	initial forever #10 clk_in = ~clk_in;
	// Interrupt pulses are counted away from the edge that launches them
	always @(negedge clk_in) begin
		cycles++;
		if (tx_interrupt_out === 1'b1) n_int++;
		if (cycles == 20000) begin
			n_mismatch++;
			finish_test();
		end
	end
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask
	task automatic wr_mode(input logic en, input logic a, input logic [1:0] d, input logic s);
		@(posedge clk_in);
		mode_wr_in <= 1'b1;
		module_enable_in <= en;
		alternate_pin_select_in <= a;
		data_parity_select_in <= d;
		stop_bit_select_in <= s;
		@(posedge clk_in);
		mode_wr_in <= 1'b0;
	endtask
	task automatic wr_stat(input logic s, input logic t, input logic b);
		@(posedge clk_in);
		status_wr_in <= 1'b1;
		tx_interrupt_select_in <= s;
		transmit_enable_in <= t;
		send_break_in <= b;
		@(posedge clk_in);
		status_wr_in <= 1'b0;
	endtask
	task automatic push(input logic [DATA_W-1:0] d, input int tries);
		int i;
		i = 0;
		@(posedge clk_in);
		tx_data_valid_in <= 1'b1;
		tx_data_in <= d;
		@(negedge clk_in);
		while (tx_data_ready_out !== 1'b1 && i++ < tries) @(negedge clk_in);
		@(posedge clk_in);
		tx_data_valid_in <= 1'b0;
	endtask
	task automatic wait_frames(input int n);
		for (int i = 0; i < 3000 && frames_p + frames_a < n; i++) @(posedge clk_in);
		#1;
	endtask
	task automatic t_reset();
		`CHK("format", DPS_8N, data_parity_select_out)
		`CHK("stop", 1'b0, stop_bit_select_out)
		`CHK("enable", 1'b0, module_enable_out)
		`CHK("empty", 1'b1, shift_register_empty_out)
		wr_stat(1'b0, 1'b1, 1'b1);
		wt(2);
		`CHK("tx_enable", 1'b0, transmit_enable_out)
		$display("t_reset done");
	endtask
	task automatic t_format();
		logic [8:0] d, e;
		int f0;
		@(posedge clk_in);
		baud_wr_in <= 1'b1;
		@(posedge clk_in);
		baud_wr_in <= 1'b0;
		f0 = n_int;
		wr_mode(1'b1, 1'b0, DPS_8N, 1'b0);
		wr_stat(1'b0, 1'b1, 1'b0);
		wt(3);
		`CHK("tx_interrupt", 2, n_int - f0)
		for (int k = 0; k < 4; k++) begin
			d = {1'b1, 8'h5a ^ 8'(k)};
			e = (k == 3) ? d : {(k == 1) ? ^d[7:0] : (k == 2) ? ~^d[7:0] : 1'b0, d[7:0]};
			wr_mode(1'b1, 1'b0, 2'(k), k[0]);
			f0 = frames_p + frames_a;
			push(d, 50);
			wait_frames(f0 + 1);
			`CHK("word", e, word_p)
			`CHK("stop", k[0], stop_bit_select_out)
			wt(40);
		end
		$display("t_format done");
	endtask
	task automatic t_fifo();
		int f0, i0;
		wr_stat(1'b1, 1'b0, 1'b0);
		for (int i = 0; i < 4; i++) push(9'h101 + 9'(i), 50);
		wt(1);
		`CHK("ready", 1'b0, tx_data_ready_out)
		`CHK("full", 1'b1, transmit_buffer_full_out)
		push(9'h0aa, 0);
		f0 = frames_p + frames_a;
		i0 = n_int;
		wr_stat(1'b1, 1'b1, 1'b0);
		wait_frames(f0 + 4);
		wt(300);
		`CHK("frames", f0 + 4, frames_p + frames_a)
		`CHK("word", 9'h104, word_p)
		`CHK("tx_interrupt", 1, n_int - i0)
		i0 = n_int;
		wr_stat(1'b1, 1'b1, 1'b1);
		wt(13 * 16);
		`CHK("line", 1'b0, line_p)
		wr_stat(1'b1, 1'b1, 1'b0);
		wt(200);
		`CHK("line", 1'b1, line_p)
		`CHK("tx_interrupt", 0, n_int - i0)
		$display("t_fifo done");
	endtask
	task automatic t_disable();
		int f0;
		push(9'h1f0, 50);
		push(9'h0f0, 50);
		wt(100);
		wr_mode(1'b0, 1'b0, DPS_9N, 1'b1);
		wt(2);
		`CHK("tx_enable", 1'b0, transmit_enable_out)
		`CHK("empty", 1'b1, shift_register_empty_out)
		`CHK("int_select", 1'b1, tx_interrupt_select_out)
		wt(200);
		f0 = frames_p + frames_a;
		wr_mode(1'b1, 1'b0, DPS_9N, 1'b1);
		wr_stat(1'b1, 1'b1, 1'b0);
		wt(400);
		`CHK("frames", f0, frames_p + frames_a)
		`CHK("format", DPS_9N, data_parity_select_out)
		// Byte write in nine-bit mode keeps only the low eight bits
		tx_data_word_in <= 1'b0;
		f0 = frames_p + frames_a;
		push(9'h1a5, 50);
		wait_frames(f0 + 1);
		`CHK("byte_word", 9'h0a5, word_p)
		tx_data_word_in <= 1'b1;
		wt(40);
		$display("t_disable done");
	endtask
	task automatic t_alt();
		int f0;
		wr_mode(1'b1, 1'b1, DPS_8N, 1'b0);
		@(posedge clk_in);
		alternate_serial_in_in <= 1'b1;
		serial_in_in <= 1'b0;
		wt(1);
		`CHK("rx_line", 1'b1, rx_line_out)
		f0 = frames_p + frames_a;
		push(9'h03c, 50);
		wait_frames(f0 + 1);
		`CHK("word", 9'h03c, word_a)
		`CHK("primary_oe_n", 1'b1, serial_out_oe_n_out)
		push(9'h0c3, 50);
		wt(60);
		wr_stat(1'b1, 1'b0, 1'b0);
		wt(2);
		`CHK("alt_oe_n", 1'b1, alternate_serial_out_oe_n_out)
		`CHK("empty", 1'b1, shift_register_empty_out)
		wt(200);
		$display("t_alt done");
	endtask
	initial begin
		repeat (16) @(posedge clk_in);
		resetn_in <= 1'b1;
		wt(3);
		t_reset();
		t_format();
		t_fifo();
		t_disable();
		t_alt();
		finish_test();
	end
endmodule
